//--- rtl/cgio_filter.sv
module cgio_filter #(
  parameter int unsigned CLK_PER_TICK = cgio_pkg::CLK_PER_TICK
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  cgio_tmr_if.timer tmr
);
  logic level_reg, level_next;
  logic [cgio_pkg::SPAN_W-1:0] cnt_reg, cnt_next;
  logic [15:0] run_reg, run_next;

  // a level that flickers back restarts the count from zero
  always_comb begin
    level_next = level_reg;
    cnt_next = cnt_reg;
    run_next = (tmr.stim == level_reg) ? 16'h0000 : ((&run_reg) ? run_reg : run_reg + 16'h0001);
    if (tmr.stim == level_reg) begin
      cnt_next = '0;
    end else if (tmr.tick) begin
      if (cnt_reg >= tmr.span) begin
        level_next = tmr.stim;
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      level_reg <= 1'b0;
      cnt_reg <= '0;
      run_reg <= 16'h0000;
    end else begin
      level_reg <= level_next;
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

  assign tmr.resp = level_reg;

  property p_filter_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    $changed(level_reg) |-> ($past(run_reg) >= 32'(tmr.span) * CLK_PER_TICK) && ($past(tmr.stim) == level_reg);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("input accepted before filter time");
endmodule

//--- rtl/cgio_pkg.sv
// Operation
// - an input change is accepted only after holding the filter time, 1 to 255 us
// - each input line keeps its own filter time setting
// - filter time is reachable only while line pick selects an input
// - each line has an inverter; set inverts the signal, clear passes it
// - level readback returns the picked line's present level on a host poll only
// - output driver select acts only when the picked line is an output
// - driver select off leaves the output circuit open
// - host driven outputs follow host output level when host output commit is written
// - exposure begin mode pulses when the sensor really starts exposing
// - exposure finish mode pulses when the sensor stops exposing
// - readout begin mode pulses when the sensor starts reading out
// - readout finish mode pulses when the sensor finishes reading out
// - first input mode pulses each time input one goes active, after filter and inverter
// - second input mode pulses each time input two goes active
// - each pulse stays active for the output pulse width, 1 to 100000 us
// - pulse width applies only to outputs in an event pulse mode
// - line pick chooses the line; lines one and two input, three and four output
package cgio_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_PERIOD_US = 1;
  localparam int unsigned CLK_PER_TICK = (CLK_HZ / 1_000_000) * TICK_PERIOD_US;
  localparam int unsigned SPAN_W = 17;

  // ----------------------------------------
  // line layout
  // ----------------------------------------
  localparam int unsigned NUM_LINES = 4;
  localparam int unsigned NUM_INPUTS = 2;
  localparam int unsigned NUM_OUTPUTS = 2;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_LINE_PICK = 8'h00;
  localparam logic [7:0] ADDR_LINE_DIRECTION = 8'h04;
  localparam logic [7:0] ADDR_INPUT_FILTER_TIME = 8'h08;
  localparam logic [7:0] ADDR_LINE_INVERT = 8'h0C;
  localparam logic [7:0] ADDR_LEVEL_READBACK = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_DRIVER_SELECT = 8'h14;
  localparam logic [7:0] ADDR_OUTPUT_PULSE_WIDTH = 8'h18;
  localparam logic [7:0] ADDR_HOST_OUTPUT_LEVEL = 8'h1C;
  localparam logic [7:0] ADDR_HOST_OUTPUT_COMMIT = 8'h20;

  // ----------------------------------------
  // limits and reset values
  // ----------------------------------------
  localparam logic [31:0] FILTER_MIN = 32'h00000001;
  localparam logic [31:0] FILTER_MAX = 32'h000000FF;
  localparam logic [31:0] WIDTH_MIN = 32'h00000001;
  localparam logic [31:0] WIDTH_MAX = 32'h000186A0;
  localparam logic [7:0] FILTER_RST = 8'h01;
  localparam logic [16:0] WIDTH_RST = 17'h00001;
  localparam logic [1:0] PICK_RST = 2'h0;

  // ----------------------------------------
  // output driver select codes
  // ----------------------------------------
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_HOST_DRIVEN = 3'h1;
  localparam logic [2:0] SRC_PULSE_EXPOSURE_BEGIN = 3'h2;
  localparam logic [2:0] SRC_PULSE_EXPOSURE_FINISH = 3'h3;
  localparam logic [2:0] SRC_PULSE_READOUT_BEGIN = 3'h4;
  localparam logic [2:0] SRC_PULSE_READOUT_FINISH = 3'h5;
  localparam logic [2:0] SRC_PULSE_ON_FIRST_INPUT = 3'h6;
  localparam logic [2:0] SRC_PULSE_ON_SECOND_INPUT = 3'h7;

endpackage

//--- rtl/cgio_pulse.sv
module cgio_pulse (
  input wire logic clk_i,
  input wire logic rstn_i,
  cgio_tmr_if.timer tmr
);
  logic [cgio_pkg::SPAN_W-1:0] cnt_reg, cnt_next;

  // one extra tick so the pulse never falls short of the width
  always_comb begin
    cnt_next = cnt_reg;
    if (tmr.stim) begin
      cnt_next = tmr.span + 1'b1;
    end else if (tmr.tick && (cnt_reg != '0)) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tmr.resp = (cnt_reg != '0);

  property p_pulse_restart;
    @(posedge clk_i) disable iff (!rstn_i)
    tmr.stim |=> tmr.resp && (cnt_reg == $past(tmr.span) + 1'b1);
  endproperty
  a_pulse_restart: assert property (p_pulse_restart) else $error("pulse not started or restarted");

  property p_pulse_end;
    @(posedge clk_i) disable iff (!rstn_i)
    $fell(tmr.resp) |-> $past(tmr.tick) && !$past(tmr.stim) && ($past(cnt_reg) == 17'h00001);
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse ended before its width");
endmodule

//--- rtl/cgio_tmr_if.sv
interface cgio_tmr_if;
  logic tick;
  logic [cgio_pkg::SPAN_W-1:0] span;
  logic stim;
  logic resp;
  modport ctrl (output tick, output span, output stim, input resp);
  modport timer (input tick, input span, input stim, output resp);
endinterface

//--- rtl/cgio_top.sv
module cgio_top #(
  parameter int unsigned CLK_PER_TICK = cgio_pkg::CLK_PER_TICK
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic [1:0] gpi_i,
  input wire logic exposure_begin_i,
  input wire logic exposure_finish_i,
  input wire logic readout_begin_i,
  input wire logic readout_finish_i,
  output logic [1:0] gpo_o
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (CLK_PER_TICK < 1 || CLK_PER_TICK > 65535) begin : g_bad_tick
    $error("CLK_PER_TICK out of range");
  end

  // ----------------------------------------
  // microsecond tick divider
  // ----------------------------------------
  logic [15:0] div_reg, div_next;
  logic tick_reg, tick_next;
  always_comb begin
    tick_next = (div_reg == 16'(CLK_PER_TICK - 1));
    div_next = tick_next ? 16'h0000 : div_reg + 16'h0001;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      div_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] gpi_meta_reg, gpi_meta_next;
  logic [1:0] gpi_sync_reg, gpi_sync_next;
  always_comb begin
    gpi_meta_next = gpi_i;
    gpi_sync_next = gpi_meta_reg;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gpi_meta_reg <= 2'h0;
      gpi_sync_reg <= 2'h0;
    end else begin
      gpi_meta_reg <= gpi_meta_next;
      gpi_sync_reg <= gpi_sync_next;
    end
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic addr_phase;
  logic wr_en;
  logic [31:0] rd_mux;
  // reads take one wait state so the answer reflects a register write just before it; an output line's level readback shows it one cycle later
  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign wr_en = wr_pend_reg;
  assign hreadyout_o = !rd_pend_reg;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_reg;
  always_comb begin
    wr_pend_next = addr_phase && hwrite_i;
    rd_pend_next = addr_phase && !hwrite_i;
    addr_next = addr_phase ? {haddr_i[7:2], 2'b00} : addr_reg;
    rdata_next = rd_pend_reg ? rd_mux : rdata_reg;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // per line configuration
  // ----------------------------------------
  logic [1:0] pick_reg, pick_next;
  logic [7:0] filter_reg [cgio_pkg::NUM_INPUTS];
  logic [7:0] filter_next [cgio_pkg::NUM_INPUTS];
  logic [3:0] inv_reg, inv_next;
  logic [2:0] src_reg [cgio_pkg::NUM_OUTPUTS];
  logic [2:0] src_next [cgio_pkg::NUM_OUTPUTS];
  logic [16:0] width_reg [cgio_pkg::NUM_OUTPUTS];
  logic [16:0] width_next [cgio_pkg::NUM_OUTPUTS];
  logic [1:0] host_lvl_reg, host_lvl_next;
  logic [1:0] commit_reg, commit_next;
  logic pick_is_input;
  logic pick_idx;
  logic pick_is_event;
  assign pick_is_input = !pick_reg[1];
  assign pick_idx = pick_reg[0];
  assign pick_is_event = (src_reg[pick_idx] != cgio_pkg::SRC_OFF) && (src_reg[pick_idx] != cgio_pkg::SRC_HOST_DRIVEN);
  always_comb begin
    pick_next = pick_reg;
    filter_next = filter_reg;
    inv_next = inv_reg;
    src_next = src_reg;
    width_next = width_reg;
    host_lvl_next = host_lvl_reg;
    commit_next = commit_reg;
    if (wr_en) begin
      if (addr_reg == cgio_pkg::ADDR_LINE_PICK) begin
        pick_next = hwdata_i[1:0];
      end else if (addr_reg == cgio_pkg::ADDR_INPUT_FILTER_TIME) begin
        if (pick_is_input && hwdata_i >= cgio_pkg::FILTER_MIN && hwdata_i <= cgio_pkg::FILTER_MAX) begin
          filter_next[pick_idx] = hwdata_i[7:0];
        end
      end else if (addr_reg == cgio_pkg::ADDR_LINE_INVERT) begin
        inv_next[pick_reg] = hwdata_i[0];
      end else if (addr_reg == cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT) begin
        if (!pick_is_input) begin
          src_next[pick_idx] = hwdata_i[2:0];
        end
      end else if (addr_reg == cgio_pkg::ADDR_OUTPUT_PULSE_WIDTH) begin
        if (!pick_is_input && pick_is_event && hwdata_i >= cgio_pkg::WIDTH_MIN && hwdata_i <= cgio_pkg::WIDTH_MAX) begin
          width_next[pick_idx] = hwdata_i[16:0];
        end
      end else if (addr_reg == cgio_pkg::ADDR_HOST_OUTPUT_LEVEL) begin
        if (!pick_is_input) begin
          host_lvl_next[pick_idx] = hwdata_i[0];
        end
      end else if (addr_reg == cgio_pkg::ADDR_HOST_OUTPUT_COMMIT) begin
        // commit updates every host driven output at once
        for (int j = 0; j < cgio_pkg::NUM_OUTPUTS; j++) begin
          if (hwdata_i[0] && src_reg[j] == cgio_pkg::SRC_HOST_DRIVEN) begin
            commit_next[j] = host_lvl_reg[j];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pick_reg <= cgio_pkg::PICK_RST;
      inv_reg <= 4'h0;
      host_lvl_reg <= 2'h0;
      commit_reg <= 2'h0;
      for (int i = 0; i < cgio_pkg::NUM_INPUTS; i++) begin
        filter_reg[i] <= cgio_pkg::FILTER_RST;
      end
      for (int j = 0; j < cgio_pkg::NUM_OUTPUTS; j++) begin
        src_reg[j] <= cgio_pkg::SRC_OFF;
        width_reg[j] <= cgio_pkg::WIDTH_RST;
      end
    end else begin
      pick_reg <= pick_next;
      filter_reg <= filter_next;
      inv_reg <= inv_next;
      src_reg <= src_next;
      width_reg <= width_next;
      host_lvl_reg <= host_lvl_next;
      commit_reg <= commit_next;
    end
  end

  // ----------------------------------------
  // input filters and output pulse timers
  // ----------------------------------------
  logic [1:0] in_clean;
  logic [1:0] in_level;
  logic [1:0] in_prev_reg, in_prev_next;
  logic [1:0] in_rise;
  logic [1:0] fire;
  logic [1:0] pulse_act;
  for (genvar i = 0; i < 2; i++) begin : g_line
    cgio_tmr_if flt_if ();
    cgio_tmr_if pls_if ();
    assign flt_if.tick = tick_reg;
    assign flt_if.span = {9'h000, filter_reg[i]};
    assign flt_if.stim = gpi_sync_reg[i];
    assign in_clean[i] = flt_if.resp;
    assign in_level[i] = in_clean[i] ^ inv_reg[i];
    assign in_rise[i] = in_level[i] && !in_prev_reg[i];
    cgio_filter #(.CLK_PER_TICK(CLK_PER_TICK)) u_filter (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tmr(flt_if.timer)
    );

    always_comb begin
      case (src_reg[i])
        cgio_pkg::SRC_PULSE_EXPOSURE_BEGIN: fire[i] = exposure_begin_i;
        cgio_pkg::SRC_PULSE_EXPOSURE_FINISH: fire[i] = exposure_finish_i;
        cgio_pkg::SRC_PULSE_READOUT_BEGIN: fire[i] = readout_begin_i;
        cgio_pkg::SRC_PULSE_READOUT_FINISH: fire[i] = readout_finish_i;
        cgio_pkg::SRC_PULSE_ON_FIRST_INPUT: fire[i] = in_rise[0];
        cgio_pkg::SRC_PULSE_ON_SECOND_INPUT: fire[i] = in_rise[1];
        default: fire[i] = 1'b0;
      endcase
    end

    assign pls_if.tick = tick_reg;
    assign pls_if.span = width_reg[i];
    assign pls_if.stim = fire[i];
    assign pulse_act[i] = pls_if.resp;
    cgio_pulse u_pulse (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tmr(pls_if.timer)
    );
  end

  // ----------------------------------------
  // output drive
  // ----------------------------------------
  logic [1:0] gpo_reg, gpo_next;
  always_comb begin
    in_prev_next = in_level;
    for (int j = 0; j < cgio_pkg::NUM_OUTPUTS; j++) begin
      if (src_reg[j] == cgio_pkg::SRC_OFF) begin
        gpo_next[j] = 1'b0;
      end else if (src_reg[j] == cgio_pkg::SRC_HOST_DRIVEN) begin
        gpo_next[j] = commit_reg[j] ^ inv_reg[2 + j];
      end else begin
        gpo_next[j] = pulse_act[j] ^ inv_reg[2 + j];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gpo_reg <= 2'h0;
      in_prev_reg <= 2'h0;
    end else begin
      gpo_reg <= gpo_next;
      in_prev_reg <= in_prev_next;
    end
  end

  assign gpo_o = gpo_reg;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [3:0] level_all;
  assign level_all = {gpo_reg, in_level};
  always_comb begin
    rd_mux = 32'h00000000;
    if (addr_reg == cgio_pkg::ADDR_LINE_PICK) begin
      rd_mux[1:0] = pick_reg;
    end else if (addr_reg == cgio_pkg::ADDR_LINE_DIRECTION) begin
      rd_mux[0] = !pick_is_input;
    end else if (addr_reg == cgio_pkg::ADDR_INPUT_FILTER_TIME) begin
      rd_mux[7:0] = pick_is_input ? filter_reg[pick_idx] : 8'h00;
    end else if (addr_reg == cgio_pkg::ADDR_LINE_INVERT) begin
      rd_mux[0] = inv_reg[pick_reg];
    end else if (addr_reg == cgio_pkg::ADDR_LEVEL_READBACK) begin
      rd_mux[0] = level_all[pick_reg];
    end else if (addr_reg == cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT) begin
      rd_mux[2:0] = pick_is_input ? 3'h0 : src_reg[pick_idx];
    end else if (addr_reg == cgio_pkg::ADDR_OUTPUT_PULSE_WIDTH) begin
      rd_mux[16:0] = pick_is_input ? 17'h00000 : width_reg[pick_idx];
    end else if (addr_reg == cgio_pkg::ADDR_HOST_OUTPUT_LEVEL) begin
      rd_mux[0] = pick_is_input ? 1'b0 : host_lvl_reg[pick_idx];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_filter_split;
    @(posedge clk_i) disable iff (!rstn_i)
    (wr_en && addr_reg == cgio_pkg::ADDR_INPUT_FILTER_TIME && pick_reg == 2'h0) |=> $stable(filter_reg[1]);
  endproperty
  a_filter_split: assert property (p_filter_split) else $error("filter write leaked to other input");
  property p_filter_gate;
    @(posedge clk_i) disable iff (!rstn_i)
    (wr_en && addr_reg == cgio_pkg::ADDR_INPUT_FILTER_TIME && !pick_is_input)
      |=> $stable(filter_reg[0]) && $stable(filter_reg[1]);
  endproperty
  a_filter_gate: assert property (p_filter_gate) else $error("filter written while output picked");
  property p_input_invert;
    @(posedge clk_i) disable iff (!rstn_i)
    in_level[0] == (in_clean[0] != inv_reg[0]);
  endproperty
  a_input_invert: assert property (p_input_invert) else $error("input polarity wrong");
  property p_readback;
    @(posedge clk_i) disable iff (!rstn_i)
    (rd_pend_reg && addr_reg == cgio_pkg::ADDR_LEVEL_READBACK)
      |=> hreadyout_o && (hrdata_o[0] == $past(level_all[pick_reg])) && (hrdata_o[31:1] == 31'h00000000);
  endproperty
  a_readback: assert property (p_readback) else $error("level readback mismatch");
  property p_src_gate;
    @(posedge clk_i) disable iff (!rstn_i)
    (wr_en && addr_reg == cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT && pick_is_input)
      |=> $stable(src_reg[0]) && $stable(src_reg[1]);
  endproperty
  a_src_gate: assert property (p_src_gate) else $error("source written while input picked");
  property p_off_open;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg[0] == cgio_pkg::SRC_OFF) [*2] |-> !gpo_o[0];
  endproperty
  a_off_open: assert property (p_off_open) else $error("off output not open");
  property p_host_commit;
    @(posedge clk_i) disable iff (!rstn_i)
    (wr_en && addr_reg == cgio_pkg::ADDR_HOST_OUTPUT_COMMIT && hwdata_i[0]
      && src_reg[0] == cgio_pkg::SRC_HOST_DRIVEN && src_next[0] == cgio_pkg::SRC_HOST_DRIVEN
      && inv_next[2] == inv_reg[2])
      |-> ##2 gpo_o[0] == ($past(host_lvl_reg[0], 2) ^ inv_reg[2]);
  endproperty
  a_host_commit: assert property (p_host_commit) else $error("host commit not applied");
  property p_host_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg[0] == cgio_pkg::SRC_HOST_DRIVEN && !(wr_en && addr_reg == cgio_pkg::ADDR_HOST_OUTPUT_COMMIT))
      |=> $stable(commit_reg[0]);
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("host level moved without commit");
  property p_exp_fire;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg[1] == cgio_pkg::SRC_PULSE_EXPOSURE_BEGIN && exposure_begin_i && !inv_reg[3]
      && $stable(src_reg[1])) |=> ##1 gpo_o[1];
  endproperty
  a_exp_fire: assert property (p_exp_fire) else $error("exposure pulse missing");
  property p_input_fire;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg[1] == cgio_pkg::SRC_PULSE_ON_FIRST_INPUT && in_rise[0]) |-> fire[1] ##1 pulse_act[1];
  endproperty
  a_input_fire: assert property (p_input_fire) else $error("input pulse missing");
  property p_width_gate;
    @(posedge clk_i) disable iff (!rstn_i)
    (wr_en && addr_reg == cgio_pkg::ADDR_OUTPUT_PULSE_WIDTH && !pick_is_event)
      |=> $stable(width_reg[0]) && $stable(width_reg[1]);
  endproperty
  a_width_gate: assert property (p_width_gate) else $error("width written outside pulse mode");
  property p_tick_rate;
    @(posedge clk_i) disable iff (!rstn_i)
    tick_reg |=> !tick_reg || (CLK_PER_TICK == 1);
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("tick faster than divider");
endmodule

//--- test/camera_io_line_conditioning_tb.sv
module camera_io_line_conditioning_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] ev = 4'h0;
  logic [1:0] lvl = 2'h0;
  logic hrdy;
  logic hresp;
  logic [31:0] hrdata;
  logic [1:0] gpi;
  logic [1:0] gpo;
  logic [15:0] len;
  int err_total = 0;
  int tests_run = 0;
  always #25 clk_i = ~clk_i;
  cgio_top #(.CLK_PER_TICK(2)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .gpi_i(gpi), .exposure_begin_i(ev[0]),
    .exposure_finish_i(ev[1]), .readout_begin_i(ev[2]), .readout_finish_i(ev[3]), .gpo_o(gpo));
  cgio_plant plant (.clk_i(clk_i), .lvl_i(lvl), .gpo_i(gpo), .gpi_o(gpi), .len_o(len));
  // ----
  // bus and check tasks
  // ----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdy_edge();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy_edge();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy_edge();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic hold(input logic v);
    int n;
    n = 0;
    while (gpo[1] !== v && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, gpo[1]}, {31'h0, v});
  endtask
  // strobes last one cycle; input modes need the pin raised and held
  task automatic fire(input int k);
    if (k < 6) ev[k-2] <= 1'b1;
    else lvl[k-6] <= 1'b1;
    @(posedge clk_i);
    ev <= 4'h0;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    int k;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(cgio_pkg::ADDR_INPUT_FILTER_TIME, 32'h1);
    rd(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    for (k = 0; k < 4; k++) begin
      wr(cgio_pkg::ADDR_LINE_PICK, 32'(k));
      rd(cgio_pkg::ADDR_LINE_PICK, 32'(k));
      rd(cgio_pkg::ADDR_LINE_DIRECTION, 32'(k / 2));
    end
    wr(cgio_pkg::ADDR_INPUT_FILTER_TIME, 32'h9);
    rd(cgio_pkg::ADDR_INPUT_FILTER_TIME, 32'h0);
    wr(cgio_pkg::ADDR_LINE_PICK, 32'h1);
    wr(cgio_pkg::ADDR_INPUT_FILTER_TIME, 32'h14);
    wr(cgio_pkg::ADDR_LINE_PICK, 32'h0);
    wr(cgio_pkg::ADDR_INPUT_FILTER_TIME, 32'hA);
    wr(cgio_pkg::ADDR_INPUT_FILTER_TIME, 32'h0);
    wr(cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT, 32'h1);
    rd(cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT, 32'h0);
    rd(cgio_pkg::ADDR_INPUT_FILTER_TIME, 32'hA);
    $display("test setup done");
    lvl <= 2'h1;
    repeat (12) @(posedge clk_i);
    rd(cgio_pkg::ADDR_LEVEL_READBACK, 32'h0);
    repeat (40) @(posedge clk_i);
    rd(cgio_pkg::ADDR_LEVEL_READBACK, 32'h1);
    wr(cgio_pkg::ADDR_LINE_INVERT, 32'h1);
    rd(cgio_pkg::ADDR_LEVEL_READBACK, 32'h0);
    wr(cgio_pkg::ADDR_LINE_INVERT, 32'h0);
    wr(cgio_pkg::ADDR_LINE_PICK, 32'h1);
    rd(cgio_pkg::ADDR_INPUT_FILTER_TIME, 32'h14);
    lvl <= 2'h0;
    $display("test input filter done");
    wr(cgio_pkg::ADDR_LINE_PICK, 32'h2);
    rd(cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT, 32'h0);
    wr(cgio_pkg::ADDR_LINE_INVERT, 32'h1);
    chk({31'h0, gpo[0]}, 32'h0);
    wr(cgio_pkg::ADDR_LINE_INVERT, 32'h0);
    wr(cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT, 32'h1);
    wr(cgio_pkg::ADDR_HOST_OUTPUT_LEVEL, 32'h1);
    chk({31'h0, gpo[0]}, 32'h0);
    wr(cgio_pkg::ADDR_HOST_OUTPUT_COMMIT, 32'h1);
    chk({31'h0, gpo[0]}, 32'h1);
    rd(cgio_pkg::ADDR_LEVEL_READBACK, 32'h1);
    wr(cgio_pkg::ADDR_LINE_INVERT, 32'h1);
    chk({31'h0, gpo[0]}, 32'h0);
    wr(cgio_pkg::ADDR_OUTPUT_PULSE_WIDTH, 32'h32);
    rd(cgio_pkg::ADDR_OUTPUT_PULSE_WIDTH, 32'h1);
    $display("test host output done");
    wr(cgio_pkg::ADDR_LINE_PICK, 32'h3);
    wr(cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT, 32'h2);
    wr(cgio_pkg::ADDR_OUTPUT_PULSE_WIDTH, 32'h5);
    wr(cgio_pkg::ADDR_OUTPUT_PULSE_WIDTH, 32'h186A1);
    rd(cgio_pkg::ADDR_OUTPUT_PULSE_WIDTH, 32'h5);
    for (k = 2; k < 8; k++) begin
      wr(cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT, 32'(k));
      fire(k);
      hold(1'b1);
      hold(1'b0);
      @(posedge clk_i);
      chk({31'h0, (len >= 16'h000A && len <= 16'h000C)}, 32'h1);
      lvl <= 2'h0;
      repeat (80) @(posedge clk_i);
    end
    wr(cgio_pkg::ADDR_OUTPUT_DRIVER_SELECT, 32'h2);
    fire(2);
    repeat (6) @(posedge clk_i);
    fire(2);
    hold(1'b0);
    @(posedge clk_i);
    chk({31'h0, (len >= 16'h0010 && len <= 16'h0014)}, 32'h1);
    $display("test pulse modes done");
    wrap_up();
  end
endmodule

//--- test/cgio_plant.sv
module cgio_plant (
  input wire logic clk_i,
  input wire logic [1:0] lvl_i,
  input wire logic [1:0] gpo_i,
  output logic [1:0] gpi_o,
  output logic [15:0] len_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] prev = 2'h0;
  logic [1:0] chg = 2'h0;
  int bounce = 0;
  logic [15:0] run = 16'h0000;
  initial gpi_o = 2'h0;
  initial len_o = 16'h0000;
  // ----
  // contacts chatter after each change, so the filter has real work
  // ----
  always @(posedge clk_i) begin
    if (lvl_i != prev) begin
      bounce = 5;
      chg = lvl_i ^ prev;
    end
    prev = lvl_i;
    if (bounce > 0) begin
      gpi_o <= gpi_o ^ chg;
      bounce--;
    end else begin
      gpi_o <= lvl_i;
    end
    if (gpo_i[1]) begin
      run <= run + 16'h0001;
    end else if (run != 16'h0000) begin
      len_o <= run;
      run <= 16'h0000;
    end
  end
endmodule
